/* File: src/asrp_pkg.sv */
//--------------------------------------------------------------
// Shared constants for the SRAM port controller
//--------------------------------------------------------------
package asrp_pkg;

	//----------------------------------------------------------
	// Widths
	//----------------------------------------------------------
	localparam int ADDR_W = 18; // Word address width
	localparam int DATA_W = 16; // Data bus width
	localparam int LANE_W = 2; // Byte lanes
	localparam int TMR_W = 4; // Wait counter width
	localparam int SYNC_STAGES = 2; // Input synchroniser depth

	//----------------------------------------------------------
	// Timing, slowest grade, in ns
	//----------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100; // Core clock period
	localparam int WRITE_PULSE_NS = 55; // Write-active overlap
	localparam int WRITE_CYCLE_TIME_NS = 70; // Write spacing
	localparam int SELECT_TO_END_NS = 60; // Select before end
	localparam int DATA_SETUP_TIME_NS = 30; // Data before end
	localparam int READ_CYCLE_TIME_NS = 70; // Read spacing
	localparam int ADDRESS_ACCESS_TIME_NS = 70; // Address access
	localparam int OE_ACCESS_NS = 35; // Output enable access
	localparam int RETENTION_RECOVERY_TIME_NS = 70; // Equal to read cycle

	//----------------------------------------------------------
	// Cycle counts, least times rounded up, never below one
	//----------------------------------------------------------
	localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS < 1 ? 1 : (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ACC_NS = ADDRESS_ACCESS_TIME_NS > OE_ACCESS_NS ?
		ADDRESS_ACCESS_TIME_NS : OE_ACCESS_NS;
	localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS < 1 ? 1 : (ACC_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RD_HOLD_CYC = ACC_CYC + SYNC_STAGES; // Pins held
	localparam int RDR_CYC = (RETENTION_RECOVERY_TIME_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(RETENTION_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	//----------------------------------------------------------
	// Pin levels
	//----------------------------------------------------------
	localparam logic PIN_LOW = 1'b0; // Driven low
	localparam logic PIN_HIGH = 1'b1; // Driven high
	localparam logic [LANE_W-1:0] LANES_OFF = 2'h3; // Both disabled
	localparam logic [LANE_W-1:0] LANES_ALL = 2'h0; // Both enabled
	localparam logic [LANE_W-1:0] OE_NONE = 2'h0; // Bus released
	localparam logic [LANE_W-1:0] OE_ALL = 2'h3; // Bus driven

	//----------------------------------------------------------
	// Controller states
	//----------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RD_ACCESS,
		ST_RD_TURN,
		ST_RETAIN,
		ST_RECOVER
	} asrp_state_type;

endpackage : asrp_pkg

/* File: src/asrp_wait_timer.sv */
`timescale 1ns/1ps
//--------------------------------------------------------------
// Loadable down counter, done when it reaches zero
//--------------------------------------------------------------
module asrp_wait_timer #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	// Status
	output logic done
);

	logic [WIDTH-1:0] count_r; // Remaining cycles

	// Load wins, otherwise count down to zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (load) begin
			count_r <= load_value;
		end else if (count_r != '0) begin
			count_r <= count_r - WIDTH'(1);
		end
	end

	// Zero means the wait has elapsed
	assign done = (count_r == '0);

endmodule : asrp_wait_timer

/* File: src/asrp_host_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Write spans overlap of both selects, WE
// - Write overlap at least 55 ns
// - Writes spaced at least 70 ns
// - Select, address, lanes 60 ns before end
// - Address valid at write start
// - Address stable until write ends
// - Data valid 30 ns before end, held after
// - Reads spaced at least 70 ns
// - Deselect around retention, recover one read cycle
module asrp_host_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// User request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [asrp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asrp_pkg::DATA_W-1:0] req_wdata,
	input wire logic [asrp_pkg::LANE_W-1:0] req_lane_en,
	output logic req_ready,
	// User response
	output logic rsp_valid,
	output logic [asrp_pkg::DATA_W-1:0] rsp_rdata,
	// Retention control
	input wire logic retention_req,
	output logic retention_active,
	// SRAM pins
	output logic chip_select_low_active,
	output logic chip_select_high_active,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic lower_lane_enable_n,
	output logic upper_lane_enable_n,
	output logic [asrp_pkg::ADDR_W-1:0] word_address,
	output logic [asrp_pkg::DATA_W-1:0] data_bus_out,
	output logic [asrp_pkg::DATA_W-1:0] data_bus_oe,
	input wire logic [asrp_pkg::DATA_W-1:0] data_bus_in
);

	//----------------------------------------------------------
	// Declarations
	//----------------------------------------------------------
	asrp_pkg::asrp_state_type state_r; // Current state
	asrp_pkg::asrp_state_type state_nxt; // Next state
	logic [asrp_pkg::DATA_W-1:0] sync1_r; // First sync stage
	logic [asrp_pkg::DATA_W-1:0] sync2_r; // Second sync stage
	logic [asrp_pkg::LANE_W-1:0] lanes_n_r; // Lane enables, low on
	logic [asrp_pkg::LANE_W-1:0] lanes_req_n; // Requested lanes
	logic [asrp_pkg::LANE_W-1:0] bus_oe_r; // Per-lane drive
	logic take_req; // Request accepted
	logic tmr_load; // Restart wait timer
	logic [asrp_pkg::TMR_W-1:0] tmr_value; // Wait length minus one
	logic tmr_done; // Wait elapsed

	//----------------------------------------------------------
	// Request acceptance
	//----------------------------------------------------------
	// A request beats a pending retention entry
	assign take_req = req_valid && req_ready && (state_r == asrp_pkg::ST_IDLE);
	// No lane asked for is taken as a full word
	assign lanes_req_n = (req_lane_en == '0) ? asrp_pkg::LANES_ALL :
		~req_lane_en;

	//----------------------------------------------------------
	// Next state
	//----------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		tmr_load = 1'b0;
		tmr_value = '0;
		case (state_r)
			asrp_pkg::ST_IDLE: begin
				if (take_req && req_write) begin
					state_nxt = asrp_pkg::ST_WR_SETUP;
				end else if (take_req) begin
					// Wait covers access plus the synchroniser
					state_nxt = asrp_pkg::ST_RD_ACCESS;
					tmr_load = 1'b1;
					tmr_value = asrp_pkg::TMR_W'(asrp_pkg::RD_HOLD_CYC - 1);
				end else if (retention_req) begin
					state_nxt = asrp_pkg::ST_RETAIN;
				end
			end
			asrp_pkg::ST_WR_SETUP: begin
				// Address and data settled, now open the pulse
				state_nxt = asrp_pkg::ST_WR_PULSE;
				tmr_load = 1'b1;
				tmr_value = asrp_pkg::TMR_W'(asrp_pkg::WP_CYC - 1);
			end
			asrp_pkg::ST_WR_PULSE: begin
				if (tmr_done) begin
					state_nxt = asrp_pkg::ST_WR_HOLD;
				end
			end
			asrp_pkg::ST_WR_HOLD: begin
				state_nxt = asrp_pkg::ST_IDLE;
			end
			asrp_pkg::ST_RD_ACCESS: begin
				if (tmr_done) begin
					state_nxt = asrp_pkg::ST_RD_TURN;
				end
			end
			asrp_pkg::ST_RD_TURN: begin
				// Device lets go of the bus during this cycle
				state_nxt = asrp_pkg::ST_IDLE;
			end
			asrp_pkg::ST_RETAIN: begin
				if (!retention_req) begin
					state_nxt = asrp_pkg::ST_RECOVER;
					tmr_load = 1'b1;
					tmr_value = asrp_pkg::TMR_W'(asrp_pkg::RDR_CYC - 1);
				end
			end
			asrp_pkg::ST_RECOVER: begin
				if (tmr_done) begin
					state_nxt = asrp_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = asrp_pkg::ST_IDLE;
			end
		endcase
	end

	// Shared wait timer
	asrp_wait_timer #(
		.WIDTH(asrp_pkg::TMR_W)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(tmr_load),
		.load_value(tmr_value),
		.done(tmr_done)
	);

	//----------------------------------------------------------
	// State and handshake registers
	//----------------------------------------------------------
	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= asrp_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Ready only for a cycle spent in idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_nxt == asrp_pkg::ST_IDLE);
		end
	end

	// Retention flag follows the retain state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			retention_active <= 1'b0;
		end else begin
			retention_active <= (state_nxt == asrp_pkg::ST_RETAIN);
		end
	end

	//----------------------------------------------------------
	// Pin registers
	//----------------------------------------------------------
	// Both selects active only inside an access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chip_select_low_active <= asrp_pkg::PIN_HIGH;
			chip_select_high_active <= asrp_pkg::PIN_LOW;
		end else if (state_nxt == asrp_pkg::ST_IDLE ||
			state_nxt == asrp_pkg::ST_RD_TURN ||
			state_nxt == asrp_pkg::ST_RETAIN ||
			state_nxt == asrp_pkg::ST_RECOVER) begin
			chip_select_low_active <= asrp_pkg::PIN_HIGH;
			chip_select_high_active <= asrp_pkg::PIN_LOW;
		end else begin
			chip_select_low_active <= asrp_pkg::PIN_LOW;
			chip_select_high_active <= asrp_pkg::PIN_HIGH;
		end
	end

	// Write enable low only in the pulse state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			write_enable_n <= asrp_pkg::PIN_HIGH;
		end else begin
			write_enable_n <= (state_nxt != asrp_pkg::ST_WR_PULSE);
		end
	end

	// Output enable low only while reading
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			output_enable_n <= asrp_pkg::PIN_HIGH;
		end else begin
			output_enable_n <= (state_nxt != asrp_pkg::ST_RD_ACCESS);
		end
	end

	// Address and lanes latched on acceptance, held through
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_address <= '0;
			lanes_n_r <= asrp_pkg::LANES_OFF;
		end else if (take_req) begin
			word_address <= req_addr;
			lanes_n_r <= lanes_req_n;
		end else if (state_nxt == asrp_pkg::ST_IDLE ||
			state_nxt == asrp_pkg::ST_RETAIN ||
			state_nxt == asrp_pkg::ST_RECOVER) begin
			lanes_n_r <= asrp_pkg::LANES_OFF;
		end
	end
	assign lower_lane_enable_n = lanes_n_r[0];
	assign upper_lane_enable_n = lanes_n_r[1];

	// Write data driven from setup through hold
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_bus_out <= '0;
			bus_oe_r <= asrp_pkg::OE_NONE;
		end else if (take_req && req_write) begin
			data_bus_out <= req_wdata;
			bus_oe_r <= asrp_pkg::OE_ALL;
		end else if (state_nxt == asrp_pkg::ST_IDLE ||
			state_nxt == asrp_pkg::ST_RD_ACCESS) begin
			bus_oe_r <= asrp_pkg::OE_NONE;
		end
	end
	assign data_bus_oe = {{8{bus_oe_r[1]}}, {8{bus_oe_r[0]}}};

	//----------------------------------------------------------
	// Read data path
	//----------------------------------------------------------
	// Two-stage synchroniser on the bus pins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= data_bus_in;
			sync2_r <= sync1_r;
		end
	end

	// Capture at the end of the access, disabled lanes zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else if (state_r == asrp_pkg::ST_RD_ACCESS && tmr_done) begin
			rsp_valid <= 1'b1;
			rsp_rdata <= sync2_r & {{8{~lanes_n_r[1]}}, {8{~lanes_n_r[0]}}};
		end else begin
			rsp_valid <= 1'b0;
		end
	end

	//----------------------------------------------------------
	// Checks
	//----------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_we_selected: assert property (
		!write_enable_n |-> !chip_select_low_active && chip_select_high_active)
		else $error("write enable low while deselected");
	a_we_pulse_len: assert property (
		$fell(write_enable_n) |=> $rose(write_enable_n))
		else $error("write pulse length wrong");
	a_wr_spacing: assert property (
		$fell(write_enable_n) |=> !$fell(write_enable_n) [*3])
		else $error("writes too close together");
	a_cs_before_end: assert property (
		$rose(write_enable_n) |-> !$past(chip_select_low_active, 2))
		else $error("select too late before write end");
	a_addr_setup: assert property (
		$fell(write_enable_n) |-> $stable(word_address) &&
		!chip_select_low_active)
		else $error("address moved at write start");
	a_addr_hold: assert property (
		$rose(write_enable_n) |-> $stable(word_address) ##1
		$stable(word_address))
		else $error("address moved at write end");
	a_data_window: assert property (
		$rose(write_enable_n) |-> $past(data_bus_oe, 2) == '1 &&
		data_bus_oe == '1 && $stable(data_bus_out))
		else $error("write data not held around pulse");
	a_rd_spacing: assert property (
		$fell(output_enable_n) |=> !$fell(output_enable_n) [*4])
		else $error("reads too close together");
	a_no_contend: assert property (
		!output_enable_n |-> data_bus_oe == '0)
		else $error("host drives bus during read");
	a_retain_desel: assert property (
		$fell(retention_active) |-> (chip_select_low_active &&
		!chip_select_high_active) [*2])
		else $error("select too soon after retention");
	a_rsp_timing: assert property (
		$fell(output_enable_n) |-> ##3 rsp_valid)
		else $error("read response not at access end");

	c_write: cover property ($rose(write_enable_n));
	c_read: cover property (rsp_valid);
	c_retain: cover property ($fell(retention_active));
	c_byte_write: cover property (!write_enable_n && lanes_n_r[1]);

endmodule : asrp_host_ctrl

/* File: verification/asrp_sram_model.sv */
`timescale 1ns/1ps
//------------------------------------------------------------
// Behavioural SRAM on the far side of the controller
//------------------------------------------------------------
module asrp_sram_model (
	// Controls
	input wire logic chip_select_low_active,
	input wire logic chip_select_high_active,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic lower_lane_enable_n,
	input wire logic upper_lane_enable_n,
	input wire logic [17:0] word_address,
	// Data bus
	input wire logic [15:0] bus_level,
	input wire logic [15:0] host_oe,
	output logic [15:0] sram_q,
	output logic [15:0] sram_en,
	// Sticky timing fault
	output logic fault
);
	logic [15:0] mem [0:262143]; // Full word array
	logic sel; // Selected with a lane on
	logic wr_on; // Write overlap
	logic [15:0] rd_lanes; // Lanes to drive
	logic [15:0] en_late; // Delayed turn-on
	realtime wr_t; // Write start, negative when none
	realtime wr_last; // Previous write start
	realtime bus_t; // Last data change
	// Deselect by either select or both lanes off
	assign sel = !chip_select_low_active && chip_select_high_active
		&& !(lower_lane_enable_n && upper_lane_enable_n);
	assign wr_on = !chip_select_low_active && chip_select_high_active
		&& !write_enable_n;
	// Only enabled lanes drive, only when reading
	assign rd_lanes = (sel && !output_enable_n && write_enable_n) ?
		{{8{!upper_lane_enable_n}}, {8{!lower_lane_enable_n}}} :
		16'h0000;
	// Turn on late, turn off at once
	assign #10 en_late = rd_lanes;
	assign sram_en = rd_lanes & en_late;
	// Stored word, refreshed on output enable as well, so a read
	// of the address just written sees the new word
	always @(word_address or wr_on or output_enable_n) begin
		sram_q = mem[word_address];
	end
	// Unwritten words read as the inverted low 16 address bits
	initial begin
		for (int i = 0; i < 262144; i++) mem[i] = ~i[15:0];
		fault = 1'b0;
		wr_t = -1.0;
		wr_last = -1000.0;
		bus_t = 0.0;
	end
	// Data change time
	always @(bus_level) bus_t = $realtime;
	// Write start: spacing
	always @(posedge wr_on) begin
		if ($realtime - wr_last < 70.0) fault = 1'b1;
		wr_t = $realtime;
		wr_last = $realtime;
	end
	// Write end: width, data setup, store enabled lanes
	always @(negedge wr_on) begin
		if (wr_t >= 0.0) begin
			if ($realtime - wr_t < 55.0) fault = 1'b1;
			if ($realtime - bus_t < 30.0) fault = 1'b1;
			if (!lower_lane_enable_n) begin
				mem[word_address][7:0] = bus_level[7:0];
			end
			if (!upper_lane_enable_n) begin
				mem[word_address][15:8] = bus_level[15:8];
			end
			wr_t = -1.0;
		end
	end
	// Address moved inside a write
	always @(word_address) if (wr_on) fault = 1'b1;
	// Both sides driving
	always @* if (|(host_oe & sram_en)) fault = 1'b1;
endmodule : asrp_sram_model

/* File: verification/async_sram_256k_x16_port_tb_top.sv */
`timescale 1ns/1ps
//------------------------------------------------------------
// Testbench for the SRAM port controller
//------------------------------------------------------------
module async_sram_256k_x16_port_tb_top;
	logic core_clk, rst_n, req_valid, req_write, retention_req;
	logic [17:0] req_addr, word_address;
	logic [15:0] req_wdata, rsp_rdata, data_bus_out, data_bus_oe;
	logic [1:0] req_lane_en;
	logic req_ready, rsp_valid, retention_active, fault;
	logic chip_select_low_active, chip_select_high_active;
	logic output_enable_n, write_enable_n;
	logic lower_lane_enable_n, upper_lane_enable_n;
	logic [15:0] bus_level, float_q, sram_q, sram_en;
	int num_errors, checks;
	// Wire level; released bits show a changing pattern
	assign bus_level = (data_bus_oe & data_bus_out)
		| (~data_bus_oe & sram_en & sram_q)
		| (~data_bus_oe & ~sram_en & float_q);
	always @(posedge core_clk) float_q <= ~bus_level;
	asrp_host_ctrl dut (.core_clk(core_clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.req_lane_en(req_lane_en), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.retention_req(retention_req),
		.retention_active(retention_active),
		.chip_select_low_active(chip_select_low_active),
		.chip_select_high_active(chip_select_high_active),
		.output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n),
		.lower_lane_enable_n(lower_lane_enable_n),
		.upper_lane_enable_n(upper_lane_enable_n),
		.word_address(word_address), .data_bus_out(data_bus_out),
		.data_bus_oe(data_bus_oe), .data_bus_in(bus_level));
	asrp_sram_model model (
		.chip_select_low_active(chip_select_low_active),
		.chip_select_high_active(chip_select_high_active),
		.output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n),
		.lower_lane_enable_n(lower_lane_enable_n),
		.upper_lane_enable_n(upper_lane_enable_n),
		.word_address(word_address), .bus_level(bus_level),
		.host_oe(data_bus_oe), .sram_q(sram_q), .sram_en(sram_en),
		.fault(fault));
	// Clock
	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;
	// Compare and count
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val
	// One request; waits for take, then for read data
	task automatic access(input logic wr, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] ln, output logic [15:0] q);
		int n;
		n = 0;
		q = 16'h0000;
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_wdata <= d;
		req_lane_en <= ln;
		@(posedge core_clk);
		while (req_ready !== 1'b1 && n < 12) begin
			@(posedge core_clk);
			n++;
		end
		req_valid <= 1'b0;
		@(posedge core_clk);
		while (!wr && rsp_valid !== 1'b1 && n < 12) begin
			@(posedge core_clk);
			n++;
		end
		q = rsp_rdata;
		if (n >= 12) check_val(32'h0, 32'h1);
	endtask : access
	// Write, skipped when wl is zero and rl is not, then read back, comparing
	task automatic wr_rd(input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] wl, input logic [1:0] rl, input logic [15:0] e);
		logic [15:0] q;
		if (wl != 2'h0 || rl == 2'h0) access(1'b1, a, d, wl, q);
		access(1'b0, a, 16'h0000, rl, q);
		check_val(q, e);
	endtask : wr_rd
	// Full words at both boundary addresses and at 15555, both full-word codes
	task automatic test_word();
		wr_rd(18'h00000, 16'hA55A, 2'h3, 2'h3, 16'hA55A);
		wr_rd(18'h3FFFF, 16'h1234, 2'h0, 2'h0, 16'h1234);
		wr_rd(18'h15555, 16'hFFFF, 2'h3, 2'h0, 16'hFFFF);
	endtask : test_word
	// Byte lanes merge and read apart
	task automatic test_lanes();
		wr_rd(18'h00ABC, 16'h1234, 2'h3, 2'h3, 16'h1234);
		wr_rd(18'h00ABC, 16'hFFAB, 2'h1, 2'h3, 16'h12AB);
		wr_rd(18'h00ABC, 16'hCDFF, 2'h2, 2'h3, 16'hCDAB);
		wr_rd(18'h00ABC, 16'h0000, 2'h0, 2'h1, 16'h00AB);
		wr_rd(18'h00ABC, 16'h0000, 2'h0, 2'h2, 16'hCD00);
	endtask : test_lanes
	// Retention entry, deselected hold, recovery, data kept
	task automatic test_retention();
		logic [15:0] q;
		int n;
		n = 0;
		retention_req <= 1'b1;
		while (retention_active !== 1'b1 && n < 10) begin
			@(posedge core_clk);
			n++;
		end
		check_val(n < 10, 32'h1);
		repeat (3) begin
			@(posedge core_clk);
			check_val({chip_select_low_active, chip_select_high_active,
				req_ready}, 32'h4);
		end
		retention_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		check_val({retention_active, chip_select_low_active, req_ready},
			32'h2);
		access(1'b0, 18'h00ABC, 16'h0000, 2'h3, q);
		check_val(q, 16'hCDAB);
	endtask : test_retention
	// Counts and verdict
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Watchdog
	initial begin
		#3000000;
		num_errors++;
		give_verdict();
	end
	// Main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		float_q = 16'h0000;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 18'h00000;
		req_wdata = 16'h0000;
		req_lane_en = 2'h0;
		retention_req = 1'b0;
		repeat (6) @(posedge core_clk);
		check_val({chip_select_low_active, chip_select_high_active,
			write_enable_n, data_bus_oe}, 32'h50000);
		rst_n <= 1'b1;
		@(posedge core_clk);
		test_word();
		test_lanes();
		test_retention();
		check_val(fault, 32'h0);
		give_verdict();
	end
endmodule : async_sram_256k_x16_port_tb_top
